// [core/vic_pkg.sv]
package vic_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NUM_SRC = 72;
	localparam int NUM_EXT = 5;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 6;
	localparam int FIELDS_PER_PRIO = 4;

	// ----------------------------------------------------------------
	// register map, one 16-bit word per address
	// ----------------------------------------------------------------
	localparam logic [5:0] ADDR_CTRL_ONE = 6'h00;
	localparam logic [5:0] ADDR_CTRL_TWO = 6'h01;
	localparam logic [5:0] ADDR_FLAG_BASE = 6'h02;
	localparam logic [5:0] ADDR_FLAG_LAST = 6'h06;
	localparam logic [5:0] ADDR_ENABLE_BASE = 6'h08;
	localparam logic [5:0] ADDR_ENABLE_LAST = 6'h0c;
	localparam logic [5:0] ADDR_PRIO_BASE = 6'h10;
	localparam logic [5:0] ADDR_PRIO_LAST = 6'h21;
	localparam logic [5:0] ADDR_CAPTURE = 6'h22;
	localparam logic [5:0] ADDR_CPU_STATUS = 6'h23;
	localparam logic [5:0] ADDR_CORE_CTRL = 6'h24;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int NEST_DIS_BIT = 15;
	localparam int TRAP_LSB = 1;
	localparam int TRAP_MSB = 6;
	localparam int ALT_SEL_BIT = 15;
	localparam int POL_MSB = 4;
	localparam int CPU_PRIO_LSB = 5;
	localparam int CPU_PRIO_MSB = 7;
	localparam int CORE_TOP_BIT = 3;
	localparam int CAP_LEVEL_LSB = 8;
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam logic [2:0] RESET_PRIO = 3'h0;

	// ----------------------------------------------------------------
	// vectors and tables
	// ----------------------------------------------------------------
	localparam logic [6:0] USER_VEC_OFFSET = 7'h08;
	localparam logic [6:0] TRAP_VEC_OSC = 7'h01;
	localparam logic [6:0] TRAP_VEC_ADDR = 7'h02;
	localparam logic [6:0] TRAP_VEC_STACK = 7'h03;
	localparam logic [6:0] TRAP_VEC_MATH = 7'h04;
	localparam logic [6:0] TRAP_VEC_DMA = 7'h05;
	localparam logic [23:0] PRIMARY_BASE = 24'h000004;
	localparam logic [23:0] ALTERNATE_BASE = 24'h000104;
	localparam int EXT_IRQ [NUM_EXT] = '{0, 20, 29, 53, 54};
	localparam int IRQ_I2C2_SLAVE = 49;
	localparam int IRQ_I2C2_MASTER = 50;
	localparam int IRQ_DMA_CH5_DONE = 61;

	typedef struct packed {
		logic [6:0] vector;
		logic [3:0] level;
	} vic_capture_type;

endpackage

// [core/vic_controller.sv]
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ns
// Function
// - eight trap vectors 0-7 at primary 0x4 and alternate 0x104 upward
// - external request 3 is irq 53 vector 61, request 4 irq 54 vector 62
// - second i2c slave is irq 49 vector 57, master irq 50 vector 58
// - dma channel 5 done is irq 61 vector 69 at 0x8e or 0x18e
// - thirty-three registers: 2 control, 5 flag, 5 enable, 18 priority, capture, cpu status, core control
// - control one holds nesting disable and the trap status flags
// - control two holds pin edge polarity and the table select
// - hardware sets each request flag, only software writes clear it
// - a source with its enable clear is never presented
// - every user source has a three-bit priority field
// - capture register latches 7-bit vector and 4-bit new level
// - captured level equals the priority of the captured vector
// - flag, enable and priority bits follow vector table order
// - irq n takes vector n plus eight
// - status bits 7:5 show the cpu level and software may write them
// - the fourth cpu priority bit is read-only to software
// - cpu level is top bit over three bits; top set or 111 masks users
// - table select set makes every vector come from the alternate table
// - pin polarity 1 triggers on falling edge, 0 on rising edge
// - nesting disable makes status bits 7:5 read-only to software
module vic_controller (
	input wire logic CLK, // core clock, 10 MHz
	input wire logic RST_N, // synchronous reset, active low
	input wire logic [5:0] ADDR, // register address
	input wire logic [15:0] WDATA, // register write data
	input wire logic WR, // write strobe
	input wire logic RD, // read strobe
	output logic [15:0] RDATA, // read data, cycle after RD
	input wire logic [71:0] SRC_REQ, // peripheral request pulses
	input wire logic [4:0] EXT_PIN, // external request pins, async
	input wire logic [5:0] TRAP_EVT, // trap pulses, control-one order
	input wire logic CPU_ACK, // cpu takes the presented vector
	input wire logic RESTORE_VALID, // cpu returns, reloads its level
	input wire logic [3:0] RESTORE_LEVEL, // level to reload
	output logic IRQ_VALID, // a vector is presented
	output logic [6:0] IRQ_VECTOR, // presented vector number
	output logic [3:0] IRQ_LEVEL, // presented new level
	output logic [23:0] IRQ_ADDR, // table word to fetch
	output logic [3:0] CPU_LEVEL // current cpu priority level
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [71:0] flag_r, flag_nxt, en_r, en_nxt, src_set;
	logic [2:0] prio_r [vic_pkg::NUM_SRC];
	logic [2:0] prio_nxt [vic_pkg::NUM_SRC];
	logic nest_dis_r, alt_sel_r;
	logic [5:0] trap_r, trap_nxt;
	logic [4:0] pol_r;
	logic [2:0] cpu_bits_r, cpu_bits_nxt;
	logic cpu_top_r, cpu_top_nxt;
	vic_pkg::vic_capture_type cap_r, cap_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic irq_valid_r;
	logic [23:0] irq_addr_r, irq_addr_nxt;
	logic [4:0] pin_s1_r, pin_s2_r, pin_prev_r, ext_edge;
	logic [71:0] ext_set;
	logic [2:0] best_lvl;
	logic [6:0] best_idx;
	logic user_hit, trap_any, sel_valid;
	logic [6:0] trap_vec;
	logic [3:0] trap_lvl;

	// true when the address falls inside a block of registers
	function automatic logic in_block(input logic [5:0] a,
		input logic [5:0] lo, input logic [5:0] hi);
		in_block = (a >= lo) && (a <= hi);
	endfunction

	// write hit on one of the single-word registers
	wire wr_ctrl1 = WR && ADDR == vic_pkg::ADDR_CTRL_ONE;
	wire wr_ctrl2 = WR && ADDR == vic_pkg::ADDR_CTRL_TWO;
	wire wr_status = WR && ADDR == vic_pkg::ADDR_CPU_STATUS;
	wire wr_core = WR && ADDR == vic_pkg::ADDR_CORE_CTRL;

	// ----------------------------------------------------------------
	// external pins: two-flop sync, then edge detect
	// ----------------------------------------------------------------
	// only the second stage and the history stage feed the detector
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			pin_s1_r <= 5'h00;
			pin_s2_r <= 5'h00;
			pin_prev_r <= 5'h00;
		end
		else
		begin
			pin_s1_r <= EXT_PIN;
			pin_s2_r <= pin_s1_r;
			pin_prev_r <= pin_s2_r;
		end
	end

	// polarity picks the edge each pin reacts to
	genvar g;
	generate
		for (g = 0; g < vic_pkg::NUM_EXT; g++)
		begin : g_edge
			assign ext_edge[g] = pol_r[g] ? (pin_prev_r[g] & ~pin_s2_r[g])
				: (~pin_prev_r[g] & pin_s2_r[g]);
		end
	endgenerate

	// pins land on their fixed request numbers
	always_comb
	begin
		ext_set = 72'h0;
		for (int k = 0; k < vic_pkg::NUM_EXT; k++)
			ext_set[vic_pkg::EXT_IRQ[k]] = ext_edge[k];
	end
	assign src_set = SRC_REQ | ext_set;

	// ----------------------------------------------------------------
	// per-source flag, enable and priority storage
	// ----------------------------------------------------------------
	// bit i sits in word i/16; priority i in word i/4, nibble i%4
	generate
		for (g = 0; g < vic_pkg::NUM_SRC; g++)
		begin : g_src
			localparam logic [5:0] FW = 6'(g / 16);
			localparam logic [5:0] PW = 6'(g / vic_pkg::FIELDS_PER_PRIO);
			localparam int PB = (g % vic_pkg::FIELDS_PER_PRIO) * 4;
			wire fhit = WR && ADDR == vic_pkg::ADDR_FLAG_BASE + FW;
			wire ehit = WR && ADDR == vic_pkg::ADDR_ENABLE_BASE + FW;
			wire phit = WR && ADDR == vic_pkg::ADDR_PRIO_BASE + PW;
			// a set in the clearing cycle wins over the write
			assign flag_nxt[g] = (fhit ? WDATA[g % 16] : flag_r[g])
				| src_set[g];
			assign en_nxt[g] = ehit ? WDATA[g % 16] : en_r[g];
			assign prio_nxt[g] = phit ? WDATA[PB+2:PB] : prio_r[g];
		end
	endgenerate

	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			flag_r <= 72'h0;
			en_r <= 72'h0;
			for (int i = 0; i < vic_pkg::NUM_SRC; i++)
				prio_r[i] <= vic_pkg::RESET_PRIO;
		end
		else
		begin
			flag_r <= flag_nxt;
			en_r <= en_nxt;
			prio_r <= prio_nxt;
		end
	end

	// ----------------------------------------------------------------
	// global control and cpu level
	// ----------------------------------------------------------------
	// trap status is sticky; a new trap beats a clearing write
	assign trap_nxt = (wr_ctrl1 ? WDATA[vic_pkg::TRAP_MSB:vic_pkg::TRAP_LSB]
		: trap_r) | TRAP_EVT;

	// cpu entry and return outrank software; top bit has no write path
	assign cpu_bits_nxt = CPU_ACK && irq_valid_r ? IRQ_LEVEL[2:0]
		: RESTORE_VALID ? RESTORE_LEVEL[2:0]
		: wr_status && !nest_dis_r
			? WDATA[vic_pkg::CPU_PRIO_MSB:vic_pkg::CPU_PRIO_LSB]
		: cpu_bits_r;
	assign cpu_top_nxt = CPU_ACK && irq_valid_r ? IRQ_LEVEL[3]
		: RESTORE_VALID ? RESTORE_LEVEL[3] : cpu_top_r;

	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			nest_dis_r <= 1'b0;
			trap_r <= 6'h00;
			alt_sel_r <= 1'b0;
			pol_r <= 5'h00;
			cpu_bits_r <= 3'h0;
			cpu_top_r <= 1'b0;
		end
		else
		begin
			if (wr_ctrl1)
				nest_dis_r <= WDATA[vic_pkg::NEST_DIS_BIT];
			if (wr_ctrl2)
			begin
				alt_sel_r <= WDATA[vic_pkg::ALT_SEL_BIT];
				pol_r <= WDATA[vic_pkg::POL_MSB:0];
			end
			trap_r <= trap_nxt;
			cpu_bits_r <= cpu_bits_nxt;
			cpu_top_r <= cpu_top_nxt;
		end
	end

	// ----------------------------------------------------------------
	// resolution
	// ----------------------------------------------------------------
	// start at the cpu level so only higher priorities can win;
	// strict compare keeps the lowest irq on a tie
	always_comb
	begin
		best_lvl = cpu_bits_r;
		best_idx = 7'h00;
		user_hit = 1'b0;
		for (int i = 0; i < vic_pkg::NUM_SRC; i++)
			if (flag_r[i] && en_r[i] && prio_r[i] > best_lvl)
			begin
				best_lvl = prio_r[i];
				best_idx = 7'(i);
				user_hit = !cpu_top_r;
			end
	end

	// trap order: oscillator, address, stack, math, dma
	assign trap_any = |trap_r[4:0];
	assign trap_vec = trap_r[0] ? vic_pkg::TRAP_VEC_OSC
		: trap_r[2] ? vic_pkg::TRAP_VEC_ADDR
		: trap_r[1] ? vic_pkg::TRAP_VEC_STACK
		: trap_r[3] ? vic_pkg::TRAP_VEC_MATH
		: vic_pkg::TRAP_VEC_DMA;
	assign trap_lvl = {1'b1, 3'h7 - trap_vec[2:0]};

	assign sel_valid = trap_any || user_hit;
	assign cap_nxt.vector = trap_any ? trap_vec
		: best_idx + vic_pkg::USER_VEC_OFFSET;
	assign cap_nxt.level = trap_any ? trap_lvl : {1'b0, best_lvl};
	// each vector is one program word, two bytes apart
	assign irq_addr_nxt = (alt_sel_r ? vic_pkg::ALTERNATE_BASE
		: vic_pkg::PRIMARY_BASE) + {16'h0000, cap_nxt.vector, 1'b0};

	// capture holds the last presented vector when nothing is pending
	always_ff @(posedge CLK)
	begin
		if (!RST_N)
		begin
			cap_r <= '0;
			irq_valid_r <= 1'b0;
			irq_addr_r <= 24'h000000;
		end
		else
		begin
			irq_valid_r <= sel_valid;
			if (sel_valid)
			begin
				cap_r <= cap_nxt;
				irq_addr_r <= irq_addr_nxt;
			end
		end
	end

	// ----------------------------------------------------------------
	// register read
	// ----------------------------------------------------------------
	// unmapped addresses and unused flag bits read zero
	always_comb
	begin
		rdata_nxt = vic_pkg::RESET_WORD;
		if (ADDR == vic_pkg::ADDR_CTRL_ONE)
			rdata_nxt = {nest_dis_r, 8'h00, trap_r, 1'b0};
		else if (ADDR == vic_pkg::ADDR_CTRL_TWO)
			rdata_nxt = {alt_sel_r, 10'h000, pol_r};
		else if (in_block(ADDR, vic_pkg::ADDR_FLAG_BASE,
			vic_pkg::ADDR_FLAG_LAST))
			rdata_nxt = 16'({8'h00, flag_r}
				>> (16 * (ADDR - vic_pkg::ADDR_FLAG_BASE)));
		else if (in_block(ADDR, vic_pkg::ADDR_ENABLE_BASE,
			vic_pkg::ADDR_ENABLE_LAST))
			rdata_nxt = 16'({8'h00, en_r}
				>> (16 * (ADDR - vic_pkg::ADDR_ENABLE_BASE)));
		else if (in_block(ADDR, vic_pkg::ADDR_PRIO_BASE,
			vic_pkg::ADDR_PRIO_LAST))
			for (int f = 0; f < vic_pkg::FIELDS_PER_PRIO; f++)
				rdata_nxt[f*4 +: 3] = prio_r[(ADDR
					- vic_pkg::ADDR_PRIO_BASE) * 4 + f];
		else if (ADDR == vic_pkg::ADDR_CAPTURE)
			rdata_nxt = {4'h0, cap_r.level, 1'b0, cap_r.vector};
		else if (ADDR == vic_pkg::ADDR_CPU_STATUS)
			rdata_nxt = {8'h00, cpu_bits_r, 5'h00};
		else if (ADDR == vic_pkg::ADDR_CORE_CTRL)
			rdata_nxt = {12'h000, cpu_top_r, 3'h0};
	end

	always_ff @(posedge CLK)
	begin
		if (!RST_N)
			rdata_r <= vic_pkg::RESET_WORD;
		else if (RD)
			rdata_r <= rdata_nxt;
	end

	assign RDATA = rdata_r;
	assign IRQ_VALID = irq_valid_r;
	assign IRQ_VECTOR = cap_r.vector;
	assign IRQ_LEVEL = cap_r.level;
	assign IRQ_ADDR = irq_addr_r;
	assign CPU_LEVEL = {cpu_top_r, cpu_bits_r};

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	property p_trap_vec;
		trap_any |=> IRQ_VALID && IRQ_VECTOR >= 7'h01 && IRQ_VECTOR <= 7'h05;
	endproperty
	a_trap_vec: assert property (p_trap_vec) else $error("trap vector bad");

	property p_ext3_flag;
		ext_edge[3] |=> flag_r[53];
	endproperty
	a_ext3_flag: assert property (p_ext3_flag) else $error("ext3 flag lost");

	property p_i2c_vec;
		!trap_any && user_hit && best_idx == 7'd49 |=> IRQ_VECTOR == 7'd57;
	endproperty
	a_i2c_vec: assert property (p_i2c_vec) else $error("i2c vector bad");

	property p_dma_ch5_done_addr;
		!trap_any && user_hit && best_idx == 7'd61 && !alt_sel_r
			|=> IRQ_ADDR == 24'h00008e && IRQ_VECTOR == 7'd69;
	endproperty
	a_dma_ch5_done_addr: assert property (p_dma_ch5_done_addr) else $error("dma_ch5_done addr bad");

	property p_flag_hold;
		!WR |=> (flag_r & $past(flag_r)) == $past(flag_r);
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag dropped");

	property p_user_gate;
		sel_valid && !trap_any |-> en_r[best_idx] && flag_r[best_idx]
			&& prio_r[best_idx] > cpu_bits_r && !cpu_top_r;
	endproperty
	a_user_gate: assert property (p_user_gate) else $error("bad winner");

	property p_level_match;
		sel_valid && !trap_any |=> IRQ_LEVEL == {1'b0, $past(best_lvl)}
			&& IRQ_VECTOR == $past(best_idx) + 7'h08;
	endproperty
	a_level_match: assert property (p_level_match) else $error("level bad");

	property p_nest_lock;
		wr_status && nest_dis_r && !CPU_ACK && !RESTORE_VALID
			|=> $stable(cpu_bits_r);
	endproperty
	a_nest_lock: assert property (p_nest_lock) else $error("level written");

	property p_top_ro;
		wr_core && !CPU_ACK && !RESTORE_VALID |=> $stable(cpu_top_r);
	endproperty
	a_top_ro: assert property (p_top_ro) else $error("top bit written");

	property p_alt_addr;
		sel_valid && alt_sel_r |=> IRQ_ADDR[23:8] == 16'h0001;
	endproperty
	a_alt_addr: assert property (p_alt_addr) else $error("table bad");

	c_dma_ch5_done: cover property (IRQ_VALID && IRQ_VECTOR == 7'd69);
	c_alt_trap: cover property (alt_sel_r && trap_any ##1 IRQ_VALID);
	c_ext_fall: cover property (pol_r[3] && ext_edge[3]);

endmodule // vic_controller

// [bench/vic_cpu_model.sv]
`timescale 1ns/1ns
// ----------------------------------------------------------------
// cpu side: takes a presented vector after a set lag
// ----------------------------------------------------------------
module vic_cpu_model (
	input wire logic clk, // core clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic irq_valid, // a vector is presented
	input wire logic arm, // one pulse: take the next vector
	input wire logic [3:0] lag, // presented cycles before taking
	output logic cpu_ack // take pulse
);
	logic armed_r;
	logic [3:0] cnt_r;

	// ack only while a vector stands, so a slow cpu never takes a stale one
	always_ff @(posedge clk)
	begin
		cpu_ack <= 1'b0;
		if (!rst_n)
		begin
			armed_r <= 1'b0;
			cnt_r <= 4'h0;
		end
		else if (arm)
		begin
			armed_r <= 1'b1;
			cnt_r <= 4'h0;
		end
		else if (armed_r && irq_valid)
		begin
			cnt_r <= cnt_r + 4'h1;
			if (cnt_r == lag)
			begin
				cpu_ack <= 1'b1;
				armed_r <= 1'b0;
			end
		end
	end
endmodule // vic_cpu_model

// [bench/vic_controller_test.sv]
`timescale 1ns/1ns
module vic_controller_test;
	// ----------------------------------------------------------------
	// stimulus and observed signals
	// ----------------------------------------------------------------
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [5:0] addr = 6'h00;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [71:0] src = 72'h0;
	logic [4:0] pin = 5'h00;
	logic [5:0] trap = 6'h00;
	logic arm = 1'b0;
	logic rs_v = 1'b0;
	logic [3:0] rs_l = 4'h0;
	logic ack;
	logic [15:0] rdata;
	logic vld;
	logic [6:0] vec;
	logic [3:0] lvl;
	logic [23:0] adr;
	logic [3:0] cpu;
	int n_fail = 0;
	int checks = 0;

	// core clock, 100 ns period
	always #50 clk = ~clk;

	vic_controller vic_controller_inst (.CLK(clk), .RST_N(rst_n),
		.ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.SRC_REQ(src), .EXT_PIN(pin), .TRAP_EVT(trap), .CPU_ACK(ack),
		.RESTORE_VALID(rs_v), .RESTORE_LEVEL(rs_l), .IRQ_VALID(vld),
		.IRQ_VECTOR(vec), .IRQ_LEVEL(lvl), .IRQ_ADDR(adr), .CPU_LEVEL(cpu));
	vic_cpu_model vic_cpu_model_inst (.clk(clk), .rst_n(rst_n),
		.irq_valid(vld), .arm(arm), .lag(4'h2), .cpu_ack(ack));

	// ----------------------------------------------------------------
	// bus, compare and wait helpers
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [23:0] s, input logic [23:0] e);
		checks++;
		if (s !== e)
		begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, s, e);
		end
	endtask

	task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [5:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk({8'h00, rdata}, {8'h00, e});
	endtask

	// two edges first, so a change of winner has landed before we look
	task automatic see(input logic [6:0] v, input logic [3:0] l,
		input logic [23:0] a);
		repeat (2) @(posedge clk);
		#1;
		for (int i = 0; i < 20 && vld !== 1'b1; i++)
			@(posedge clk) #1;
		chk(24'(vld), 24'h1);
		chk(24'(vec), 24'(v));
		chk(24'(lvl), 24'(l));
		chk(adr, a);
	endtask

	// eight cycles covers the slowest path, a pin through its synchroniser
	task automatic quiet();
		repeat (8) @(posedge clk);
		#1 chk(24'(vld), 24'h0);
	endtask

	task automatic src_on(input int n, input logic [2:0] p);
		wr_reg(6'h08 + 6'(n / 16), 16'h0001 << (n % 16));
		wr_reg(6'h10 + 6'(n / 4), 16'(p) << (4 * (n % 4)));
	endtask

	task automatic pulse(input int n);
		@(posedge clk);
		src[n] <= 1'b1;
		@(posedge clk);
		src <= 72'h0;
	endtask

	task automatic set_lvl(input logic [3:0] l);
		@(posedge clk);
		rs_v <= 1'b1;
		rs_l <= l;
		@(posedge clk);
		rs_v <= 1'b0;
		#1 chk(24'(cpu), 24'(l));
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// reset values, unmapped and read-only places
	task automatic t_regs();
		rd_chk(6'h00, 16'h0000);
		wr_reg(6'h3f, 16'hffff);
		rd_chk(6'h3f, 16'h0000);
		wr_reg(6'h22, 16'hffff);
		rd_chk(6'h22, 16'h0000);
		wr_reg(6'h24, 16'h0008);
		rd_chk(6'h24, 16'h0000);
		chk(24'(cpu), 24'h0);
		wr_reg(6'h06, 16'hff00);
		rd_chk(6'h06, 16'h0000);
		wr_reg(6'h21, 16'h7777);
		rd_chk(6'h21, 16'h7777);
	endtask

	// dma channel 5: vector, capture, take, table switch, clearing
	task automatic t_dma_ch5_done();
		src_on(61, 3'h3);
		pulse(61);
		see(7'h45, 4'h3, 24'h00008e);
		rd_chk(6'h22, 16'h0345);
		rd_chk(6'h05, 16'h2000);
		@(posedge clk);
		arm <= 1'b1;
		@(posedge clk);
		arm <= 1'b0;
		quiet();
		chk(24'(cpu), 24'h3);
		rd_chk(6'h05, 16'h2000);
		wr_reg(6'h01, 16'h8000);
		set_lvl(4'h0);
		see(7'h45, 4'h3, 24'h00018e);
		wr_reg(6'h05, 16'h0000);
		quiet();
		wr_reg(6'h01, 16'h0000);
	endtask

	// equal priority: lower request number wins; disabled stays silent
	task automatic t_tie();
		wr_reg(6'h0b, 16'h0006);
		wr_reg(6'h1c, 16'h0220);
		@(posedge clk);
		src[49] <= 1'b1;
		src[50] <= 1'b1;
		@(posedge clk);
		src <= 72'h0;
		see(7'h39, 4'h2, 24'h000076);
		wr_reg(6'h05, 16'h0004);
		see(7'h3a, 4'h2, 24'h000078);
		wr_reg(6'h0b, 16'h0000);
		quiet();
		wr_reg(6'h05, 16'h0000);
	endtask

	// pin edges of both polarities, wrong edge ignored
	task automatic t_pins();
		src_on(53, 3'h1);
		@(posedge clk);
		pin[3] <= 1'b1;
		see(7'h3d, 4'h1, 24'h00007e);
		wr_reg(6'h05, 16'h0000);
		pin[3] <= 1'b0;
		quiet();
		wr_reg(6'h01, 16'h0010);
		wr_reg(6'h05, 16'h0000);
		src_on(54, 3'h2);
		pin[4] <= 1'b1;
		quiet();
		@(posedge clk);
		pin[4] <= 1'b0;
		see(7'h3e, 4'h2, 24'h000080);
		wr_reg(6'h0b, 16'h0000);
		wr_reg(6'h05, 16'h0000);
		wr_reg(6'h01, 16'h0000);
	endtask

	// request 0 placement, cpu level masking, nesting disable
	task automatic t_mask();
		src_on(0, 3'h5);
		pulse(0);
		see(7'h08, 4'h5, 24'h000014);
		rd_chk(6'h02, 16'h0001);
		set_lvl(4'h8);
		quiet();
		set_lvl(4'h5);
		quiet();
		set_lvl(4'h0);
		wr_reg(6'h23, 16'h00e0);
		#1 chk(24'(cpu), 24'h7);
		quiet();
		wr_reg(6'h00, 16'h8000);
		wr_reg(6'h23, 16'h0000);
		rd_chk(6'h23, 16'h00e0);
		wr_reg(6'h00, 16'h0000);
		wr_reg(6'h23, 16'h0000);
		see(7'h08, 4'h5, 24'h000014);
	endtask

	// traps in both tables, ahead of the pending user request
	task automatic t_traps();
		logic [6:0] tv [5] = '{7'h01, 7'h03, 7'h02, 7'h04, 7'h05};
		@(posedge clk);
		trap <= 6'h11;
		@(posedge clk);
		trap <= 6'h00;
		see(7'h01, 4'he, 24'h000006);
		rd_chk(6'h00, 16'h0022);
		wr_reg(6'h01, 16'h8000);
		for (int k = 0; k < 5; k++)
		begin
			wr_reg(6'h00, 16'h0000);
			trap[k] <= 1'b1;
			@(posedge clk);
			trap <= 6'h00;
			see(tv[k], 4'hf - 4'(tv[k]), 24'h104 + 24'(tv[k]) * 24'h2);
		end
		wr_reg(6'h00, 16'h0000);
		see(7'h08, 4'h5, 24'h000114);
		@(posedge clk);
		trap <= 6'h20;
		@(posedge clk);
		trap <= 6'h00;
		rd_chk(6'h00, 16'h0040);
		see(7'h08, 4'h5, 24'h000114);
		wr_reg(6'h00, 16'h0000);
		wr_reg(6'h02, 16'h0000);
		quiet();
	endtask

	// main sequence after five cycles of reset
	initial
	begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_dma_ch5_done();
		t_tie();
		t_pins();
		t_mask();
		t_traps();
		stop_test();
	end

	// the run needs under a thousand cycles, so this only cuts a hang
	initial
	begin
		repeat (5000) @(posedge clk);
		n_fail++;
		stop_test();
	end
endmodule // vic_controller_test
